/* File: hdl/irc_infrared_cfg.sv */
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`include "irc_params.svh"
// Operation
// (RL1) mode bit 0 enables the musical-instrument serial option, reset 0.
// (RL2) mode bit 1 enables high-speed baud, reset 0; bits 7:2 reserved.
// (RL3) option bit 0 sets receive polarity: 0 active high, 1 active low.
// (RL4) option bit 1 sets transmit polarity: 0 active high (reset), 1 low.
// (RL5) option bit 2 selects duplex: 0 full (reset), 1 half.
// (RL6) option bits 5:3 select port modulation mode, 000 standard serial at reset.
// (RL7) option bits 7:6 route port: 00 serial, 01 infrared, else none.
// (RL8) timeout register blanks opposite direction, 100 us per count, 0 to 10 ms.
// (RL9) zero timeout blanks only during activity; each count adds 100 us.
// (RL10) software never programs timeout values 0x65 through 0xff.
// (RL11) blanking applies only in half duplex; full duplex directions independent.
// (RL12) all three registers read back last write and reload defaults on reset.
module irc_infrared_cfg #(
  parameter int BlankStepCycles = `IRC_BLANK_STEP_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input irc_pkg::irc_ahb_req_type ahbReq,
  output irc_pkg::irc_ahb_rsp_type ahbRsp,
  output irc_pkg::irc_cfg_type cfg,
  input wire logic txData,
  input wire logic txActive,
  input wire logic rxActive,
  output logic rxData,
  output logic rxBlank,
  output logic txBlank,
  input wire logic serialReceivePin,
  input wire logic infrared_receive_pin,
  output logic serialTransmitPin,
  output logic infrared_transmit_pin
);
  import irc_pkg::*;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [1:0] modeReg_q;
  logic [7:0] optReg_q;
  logic [7:0] blankReg_q;
  logic rdTake;
  logic [7:0] rdIdx;
  logic wrEn;
  logic [7:0] wrIdx;
  logic [7:0] wrData;
  logic [7:0] rdValue;
  logic wrMode;
  logic wrOpt;
  logic wrBlank;

  // ----------------------------------------
  // pin synchronisers and pin state
  // ----------------------------------------
  logic serRx1_q;
  logic serRx2_q;
  logic irRx1_q;
  logic irRx2_q;
  logic rxRaw;
  logic rxPol;
  logic txPol;
  logic txLevel;
  irc_route_type route;

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  function automatic logic [7:0] regRead(
    input logic [7:0] idx,
    input logic [1:0] modeV,
    input logic [7:0] optV,
    input logic [7:0] blankV
  );
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IRC_IDX_MODE: v = {6'h00, modeV}; // RL2
      `IRC_IDX_OPT: v = optV;
      `IRC_IDX_BLANK: v = blankV;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : regRead

  function automatic logic applyPol(input logic level, input logic activeLow);
    return level ^ activeLow;
  endfunction : applyPol

  function automatic logic wrSel(input logic en, input logic [7:0] idx, input logic [7:0] want);
    return en && (idx == want);
  endfunction : wrSel

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  irc_ahb_slave u_bus (
    .core_clk(core_clk),
    .rst(rst),
    .req(ahbReq),
    .rdValue(rdValue),
    .rsp(ahbRsp),
    .rdTake(rdTake),
    .rdIdx(rdIdx),
    .wrEn(wrEn),
    .wrIdx(wrIdx),
    .wrData(wrData)
  );

  // a write completing in the same edge as a read address wins the readback
  always_comb begin
    if (wrSel(wrEn, wrIdx, rdIdx)) begin
      rdValue = regRead(rdIdx, wrData[1:0], wrData, wrData); // RL12
    end else begin
      rdValue = regRead(rdIdx, modeReg_q, optReg_q, blankReg_q); // RL12
    end
  end

  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  // flops and bypass decode with the same wrSel compare so they cannot disagree
  assign wrMode = wrSel(wrEn, wrIdx, `IRC_IDX_MODE);
  assign wrOpt = wrSel(wrEn, wrIdx, `IRC_IDX_OPT);
  assign wrBlank = wrSel(wrEn, wrIdx, `IRC_IDX_BLANK);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      modeReg_q <= 2'(`IRC_RST_MODE); // RL12
    end else if (wrMode) begin
      modeReg_q <= wrData[1:0]; // RL1
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      optReg_q <= `IRC_RST_OPT; // RL12
    end else if (wrOpt) begin
      optReg_q <= wrData; // RL6
    end
  end

  // reserved values are stored as written; the timer just counts longer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blankReg_q <= `IRC_RST_BLANK; // RL12
    end else if (wrBlank) begin
      blankReg_q <= wrData; // RL8
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  assign rxPol = optReg_q[`IRC_OPT_RXPOL];
  assign txPol = optReg_q[`IRC_OPT_TXPOL];
  assign route = irc_route_type'(optReg_q[`IRC_OPT_ROUTE_LO +: 2]);

  always_comb begin
    cfg.midiEnable = modeReg_q[`IRC_MODE_MIDI]; // RL1
    cfg.highSpeed = modeReg_q[`IRC_MODE_FAST]; // RL2
    cfg.rxActiveLow = rxPol;
    cfg.txActiveLow = txPol;
    cfg.halfDuplex = optReg_q[`IRC_OPT_DUPLEX]; // RL5
    cfg.portMode = irc_mode_type'(optReg_q[`IRC_OPT_PMODE_LO +: 3]); // RL6
    cfg.route = route;
    cfg.blankTime = blankReg_q;
  end

  // ----------------------------------------
  // half-duplex blanking
  // ----------------------------------------
  // transmit activity blanks receive
  irc_blank_timer #(
    .TickCycles(BlankStepCycles)
  ) u_rx_blank (
    .core_clk(core_clk),
    .rst(rst),
    .enable(cfg.halfDuplex),
    .active(txActive),
    .holdCount(blankReg_q),
    .blank(rxBlank)
  );

  // receive activity blanks transmit
  irc_blank_timer #(
    .TickCycles(BlankStepCycles)
  ) u_tx_blank (
    .core_clk(core_clk),
    .rst(rst),
    .enable(cfg.halfDuplex),
    .active(rxActive),
    .holdCount(blankReg_q),
    .blank(txBlank)
  );

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serRx1_q <= 1'b0;
      serRx2_q <= 1'b0;
      irRx1_q <= 1'b0;
      irRx2_q <= 1'b0;
    end else begin
      serRx1_q <= serialReceivePin;
      serRx2_q <= serRx1_q;
      irRx1_q <= infrared_receive_pin;
      irRx2_q <= irRx1_q;
    end
  end

  always_comb begin
    case (route)
      IRC_RT_SERIAL: rxRaw = serRx2_q; // RL7
      IRC_RT_IR: rxRaw = irRx2_q; // RL7
      default: rxRaw = rxPol; // unrouted: reads as idle
    endcase
  end

  // blanked data reads as idle so the engine sees no start edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxData <= 1'b0;
    end else if (rxBlank) begin
      rxData <= 1'b0; // RL11
    end else begin
      rxData <= applyPol(rxRaw, rxPol); // RL3
    end
  end

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  assign txLevel = applyPol(txData && !txBlank, txPol); // RL4

  always_ff @(posedge core_clk) begin
    if (rst) begin
      serialTransmitPin <= 1'b0;
      infrared_transmit_pin <= 1'b0;
    end else begin
      serialTransmitPin <= (route == IRC_RT_SERIAL) ? txLevel : txPol; // RL7
      infrared_transmit_pin <= (route == IRC_RT_IR) ? txLevel : txPol; // RL7
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_defaults: assert property ($past(rst) |-> modeReg_q == 2'b00 && optReg_q == 8'h00 // RL12
    && blankReg_q == 8'h03)
    else $error("registers not at defaults after reset");

  a_mode_write: assert property (wrEn && wrIdx == `IRC_IDX_MODE |=> cfg.midiEnable == $past(wrData[0]) // RL1
    && cfg.highSpeed == $past(wrData[1]))
    else $error("mode register write not applied");

  a_readback_data: assert property (rdTake && ahbReq.haddr == `IRC_ADDR_OF(`IRC_IDX_OPT) && !wrEn // RL12
    |=> ahbRsp.hrdata == {24'h00_0000, optReg_q})
    else $error("option register readback wrong");

  a_mode_reserved: assert property (rdTake && ahbReq.haddr == `IRC_ADDR_OF(`IRC_IDX_MODE) // RL2
    |=> ahbRsp.hrdata[31:2] == 30'h0000_0000)
    else $error("reserved mode bits read non-zero");

  a_opt_write: assert property (wrEn && wrIdx == `IRC_IDX_OPT |=> cfg.rxActiveLow == $past(wrData[0]) // RL5
    && cfg.txActiveLow == $past(wrData[1]) && cfg.halfDuplex == $past(wrData[2]))
    else $error("option polarity or duplex bits not applied");

  a_blank_write: assert property (wrEn && wrIdx == `IRC_IDX_BLANK |=> cfg.blankTime == $past(wrData)) // RL8
    else $error("timeout register write not applied");

  a_write_ignored: assert property (wrEn && !(wrIdx inside {`IRC_IDX_MODE, `IRC_IDX_OPT, `IRC_IDX_BLANK}) // RL12
    |=> $stable(modeReg_q) && $stable(optReg_q) && $stable(blankReg_q))
    else $error("unmapped write changed a register");

  a_blank_readback: assert property (rdTake && ahbReq.haddr == `IRC_ADDR_OF(`IRC_IDX_BLANK) && !wrEn // RL12
    |=> ahbRsp.hrdata == {24'h00_0000, blankReg_q})
    else $error("timeout register readback wrong");

  a_reset_outputs: assert property ($past(rst) |-> !rxData && !rxBlank && !txBlank // RL12
    && !serialTransmitPin && !infrared_transmit_pin)
    else $error("outputs not idle after reset");

  // ----------------------------------------
  // pin path checks
  // ----------------------------------------
  a_rx_polarity: assert property (!rxBlank && route == IRC_RT_IR ##1 !$past(rst) // RL3
    |-> rxData == ($past(irRx2_q) ^ $past(rxPol)))
    else $error("receive polarity wrong");

  a_tx_polarity: assert property (route == IRC_RT_IR && !txBlank // RL4
    |=> infrared_transmit_pin == ($past(txData) ^ $past(txPol)))
    else $error("transmit polarity wrong");

  a_route_none: assert property (route[1] |=> serialTransmitPin == $past(txPol) // RL7
    && infrared_transmit_pin == $past(txPol))
    else $error("unrouted port drives data");

  a_full_duplex: assert property (!cfg.halfDuplex [*2] |-> !rxBlank && !txBlank) // RL5
    else $error("blanking seen in full duplex");

  a_mode_field: assert property (wrEn && wrIdx == `IRC_IDX_OPT // RL6
    |=> cfg.portMode == irc_mode_type'($past(wrData[5:3])) && cfg.route == irc_route_type'($past(wrData[7:6])))
    else $error("port mode field not applied");

  a_bus_okay: assert property (ahbRsp.hreadyout && !ahbRsp.hresp)
    else $error("bus response not ready and okay");

  a_rx_serial: assert property (!rxBlank && route == IRC_RT_SERIAL // RL3
    |=> rxData == ($past(serRx2_q) ^ $past(rxPol)))
    else $error("serial receive path wrong");

  a_serial_tx: assert property (route == IRC_RT_SERIAL && !txBlank // RL7
    |=> serialTransmitPin == ($past(txData) ^ $past(txPol)) && infrared_transmit_pin == $past(txPol))
    else $error("serial transmit route wrong");

  a_tx_blanked: assert property (txBlank |=> serialTransmitPin == $past(txPol) // RL11
    && infrared_transmit_pin == $past(txPol))
    else $error("blanked transmit drives data");

  a_rx_blanked: assert property (rxBlank || route[1] |=> !rxData) // RL11
    else $error("blanked or unrouted receive passes data");

  a_half_rx_blank: assert property (cfg.halfDuplex && $rose(txActive) |=> rxBlank) // RL11
    else $error("transmit activity did not blank receive");

  a_half_tx_blank: assert property (cfg.halfDuplex && $rose(rxActive) |=> txBlank) // RL11
    else $error("receive activity did not blank transmit");

  c_half_hold: cover property (cfg.halfDuplex && $fell(txActive) ##[1:1000] $fell(rxBlank));
  c_write_timeout: cover property (wrEn && wrIdx == `IRC_IDX_BLANK);
  c_ir_route_tx: cover property (route == IRC_RT_IR && txData);
  c_unmapped_read: cover property (rdTake && rdIdx == 8'hf3);
  c_tx_blanked: cover property (txBlank && txData);

endmodule : irc_infrared_cfg

/* File: common/irc_params.svh */
`ifndef IRC_PARAMS_SVH
`define IRC_PARAMS_SVH
// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define IRC_IDX_MODE 8'hf0
`define IRC_IDX_OPT 8'hf1
`define IRC_IDX_BLANK 8'hf2
`define IRC_ADDR_OF(idx) ({22'h00_0000, (idx), 2'b00})
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define IRC_MODE_MIDI 0
`define IRC_MODE_FAST 1
`define IRC_OPT_RXPOL 0
`define IRC_OPT_TXPOL 1
`define IRC_OPT_DUPLEX 2
`define IRC_OPT_PMODE_LO 3
`define IRC_OPT_ROUTE_LO 6
`define IRC_RST_MODE 8'h00
`define IRC_RST_OPT 8'h00
`define IRC_RST_BLANK 8'h03
// ----------------------------------------
// timing
// ----------------------------------------
`define IRC_CLK_PERIOD_PS 8000
`define IRC_BLANK_STEP_PS 100000000
`define IRC_BLANK_STEP_CYC ((`IRC_BLANK_STEP_PS + `IRC_CLK_PERIOD_PS - 1) / `IRC_CLK_PERIOD_PS)
`endif

/* File: common/irc_pkg.sv */
package irc_pkg;
  typedef enum logic [2:0] {
    IRC_PM_UART = 3'h0, IRC_PM_SIRA = 3'h1, IRC_PM_ASK = 3'h2, IRC_PM_SIRB = 3'h3,
    IRC_PM_HDLC = 3'h4, IRC_PM_4PPM = 3'h5, IRC_PM_CIR = 3'h6, IRC_PM_RAW = 3'h7
  } irc_mode_type;
  typedef enum logic [1:0] {
    IRC_RT_SERIAL = 2'h0, IRC_RT_IR = 2'h1, IRC_RT_AUX = 2'h2, IRC_RT_OFF = 2'h3
  } irc_route_type;
  typedef enum logic [1:0] {BLK_IDLE = 2'b00, BLK_BUSY = 2'b01, BLK_HOLD = 2'b11} irc_blank_state_type;
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } irc_ahb_req_type;
  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } irc_ahb_rsp_type;
  typedef struct packed {
    logic midiEnable;
    logic highSpeed;
    logic rxActiveLow;
    logic txActiveLow;
    logic halfDuplex;
    irc_mode_type portMode;
    irc_route_type route;
    logic [7:0] blankTime;
  } irc_cfg_type;
endpackage : irc_pkg

/* File: hdl/irc_blank_timer.sv */
`timescale 1ns/100ps
module irc_blank_timer #(
  parameter int TickCycles = 12500
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic active,
  input wire logic [7:0] holdCount,
  output logic blank
);
  import irc_pkg::*;
  irc_blank_state_type state_q, state_d;
  logic [7:0] left_q;
  logic [$clog2(TickCycles)-1:0] cyc_q;
  logic tick;
  int heldCyc_q;
  int holdTarget_q;
  assign tick = (cyc_q == ($bits(cyc_q))'(TickCycles - 1));
  always_comb begin
    state_d = state_q;
    case (state_q)
      BLK_IDLE: if (active) state_d = BLK_BUSY;
      BLK_BUSY: if (!active) state_d = (holdCount == 8'h00) ? BLK_IDLE : BLK_HOLD; // RL9
      BLK_HOLD: if (active) state_d = BLK_BUSY; else if (tick && left_q == 8'h01) state_d = BLK_IDLE; // RL8
      default: state_d = BLK_IDLE;
    endcase
    if (!enable) state_d = BLK_IDLE; // RL11
  end
  always_ff @(posedge core_clk) begin
    state_q <= rst ? BLK_IDLE : state_d;
    blank <= rst ? 1'b0 : (state_d != BLK_IDLE);
  end
  always_ff @(posedge core_clk) begin
    if (rst || state_q != BLK_HOLD || tick) cyc_q <= '0;
    else cyc_q <= cyc_q + 1'b1;
  end
  always_ff @(posedge core_clk) begin
    if (rst) left_q <= 8'h00;
    else if (state_q == BLK_BUSY) left_q <= holdCount; // RL8
    else if (state_q == BLK_HOLD && tick) left_q <= left_q - 8'h01;
  end
  always_ff @(posedge core_clk) heldCyc_q <= (state_q == BLK_HOLD) ? heldCyc_q + 1 : 0;
  always_ff @(posedge core_clk) if (state_q == BLK_BUSY) holdTarget_q <= int'(holdCount);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_zero_hold_drop: assert property (enable && state_q == BLK_BUSY && !active && holdCount == 8'h00 |=> !blank) // RL9
    else $error("blank held with zero timeout");
  a_full_duplex_free: assert property (!enable |=> !blank) // RL11
    else $error("blank asserted in full duplex");
  a_hold_length: assert property (state_q == BLK_HOLD && state_d == BLK_IDLE && enable // RL8
    |-> heldCyc_q == holdTarget_q * TickCycles - 1)
    else $error("hold time differs from count times step");
endmodule : irc_blank_timer

/* File: hdl/irc_ahb_slave.sv */
`timescale 1ns/100ps
module irc_ahb_slave (
  input wire logic core_clk,
  input wire logic rst,
  input irc_pkg::irc_ahb_req_type req,
  input wire logic [7:0] rdValue,
  output irc_pkg::irc_ahb_rsp_type rsp,
  output logic rdTake,
  output logic [7:0] rdIdx,
  output logic wrEn,
  output logic [7:0] wrIdx,
  output logic [7:0] wrData
);
  import irc_pkg::*;
  logic take, hit, wrPend_q;
  logic [7:0] wrIdx_q;
  // --------------------------------------
  // address phase decode
  // --------------------------------------
  assign take = req.hsel && req.htrans[1] && req.hready;
  assign hit = (req.haddr[31:10] == 22'h00_0000) && (req.haddr[1:0] == 2'b00);
  assign rdIdx = req.haddr[9:2];
  assign rdTake = take && !req.hwrite;
  assign wrEn = wrPend_q;
  assign wrIdx = wrIdx_q;
  assign wrData = req.hwdata[7:0];
  always_ff @(posedge core_clk) begin
    wrPend_q <= rst ? 1'b0 : (take && req.hwrite && hit);
    wrIdx_q <= rst ? 8'h00 : req.haddr[9:2];
  end
  // zero wait states: read data registered at the address phase edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp <= '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000};
    end else begin
      rsp.hreadyout <= 1'b1;
      rsp.hresp <= 1'b0;
      if (rdTake) rsp.hrdata <= hit ? {24'h00_0000, rdValue} : 32'h0000_0000;
    end
  end
endmodule : irc_ahb_slave

/* File: sim/tb.sv */
`timescale 1ns/100ps
`include "irc_params.svh"
module tb;
  import irc_pkg::*;
  localparam int Step = 4;
  localparam int Limit = 20000;
  logic core_clk, rst, txData, txActive, rxActive, serialReceivePin, infrared_receive_pin;
  logic rxData, rxBlank, txBlank, serialTransmitPin, infrared_transmit_pin;
  irc_ahb_req_type reqDrv, ahbReq;
  irc_ahb_rsp_type ahbRsp;
  irc_cfg_type cfg;
  logic [7:0] modeV, optV, blankV;
  logic [31:0] rd;
  int errors, checks, cycles;

  irc_infrared_cfg #(.BlankStepCycles(Step)) u_dut (.core_clk(core_clk), .rst(rst), .ahbReq(ahbReq),
    .ahbRsp(ahbRsp), .cfg(cfg), .txData(txData), .txActive(txActive), .rxActive(rxActive),
    .rxData(rxData), .rxBlank(rxBlank), .txBlank(txBlank), .serialReceivePin(serialReceivePin),
    .infrared_receive_pin(infrared_receive_pin), .serialTransmitPin(serialTransmitPin),
    .infrared_transmit_pin(infrared_transmit_pin));

  // ----------------------------------------
  // clock, bus glue, timeout
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // single slave, so its ready is the bus ready
  always_comb begin
    ahbReq = reqDrv;
    ahbReq.hready = ahbRsp.hreadyout;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == Limit) begin
      errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic test_done();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  function automatic logic [31:0] exp_cfg();
    return {14'h0000, modeV[0], modeV[1], optV[0], optV[1], optV[2], optV[5:3], optV[7:6], blankV};
  endfunction : exp_cfg

  // wait states tolerated: both phases wait on ready
  task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [7:0] val);
    @(posedge core_clk);
    reqDrv.hsel <= 1'b1;
    reqDrv.haddr <= `IRC_ADDR_OF(idx);
    reqDrv.htrans <= 2'b10;
    reqDrv.hwrite <= wr;
    reqDrv.hsize <= 3'b010;
    do @(posedge core_clk); while (ahbRsp.hreadyout !== 1'b1);
    reqDrv.htrans <= 2'b00;
    reqDrv.hsel <= 1'b0;
    reqDrv.hwdata <= {24'h00_0000, val};
    do @(posedge core_clk); while (ahbRsp.hreadyout !== 1'b1);
    rd = ahbRsp.hrdata;
    chk_bit(ahbRsp.hresp, 1'b0);
  endtask : bus_xfer

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] val);
    bus_xfer(1'b1, idx, val);
    if (idx == `IRC_IDX_MODE) modeV = val & 8'h03;
    if (idx == `IRC_IDX_OPT) optV = val;
    if (idx == `IRC_IDX_BLANK) blankV = val;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
    bus_xfer(1'b0, idx, 8'h00);
    chk_word(rd, {24'h00_0000, exp});
  endtask : reg_rd

  task automatic read_all();
    reg_rd(`IRC_IDX_MODE, modeV);
    reg_rd(`IRC_IDX_OPT, optV);
    reg_rd(`IRC_IDX_BLANK, blankV);
    chk_word({14'h0000, cfg}, exp_cfg());
  endtask : read_all

  // pins follow the routed port one (transmit) and three (receive) edges on
  task automatic route_check(input logic [7:0] ov, input logic btx, input logic brx);
    logic [1:0] rt;
    rt = ov[7:6];
    reg_wr(`IRC_IDX_OPT, ov);
    @(posedge core_clk);
    txData <= btx;
    serialReceivePin <= brx;
    infrared_receive_pin <= ~brx;
    repeat (4) @(posedge core_clk);
    #1;
    chk_word({14'h0000, cfg}, exp_cfg());
    chk_bit(serialTransmitPin, (rt == 2'b00) ? btx ^ ov[1] : ov[1]);
    chk_bit(infrared_transmit_pin, (rt == 2'b01) ? btx ^ ov[1] : ov[1]);
    chk_bit(rxData, (rt == 2'b00) ? brx ^ ov[0] : (rt == 2'b01) ? ~brx ^ ov[0] : 1'b0);
  endtask : route_check

  // blank rises one edge after activity, falls n*Step+1 edges after it ends
  task automatic blank_check(input logic [7:0] n, input logic useTx);
    reg_wr(`IRC_IDX_BLANK, n);
    @(posedge core_clk);
    txData <= 1'b1;
    if (useTx) txActive <= 1'b1;
    else rxActive <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_bit(useTx ? rxBlank : txBlank, 1'b1);
    @(posedge core_clk);
    txActive <= 1'b0;
    rxActive <= 1'b0;
    repeat (n * Step) @(posedge core_clk);
    #1;
    chk_bit(useTx ? rxBlank : txBlank, 1'b1);
    chk_bit(serialTransmitPin, useTx);
    @(posedge core_clk);
    #1;
    chk_bit(useTx ? rxBlank : txBlank, 1'b0);
  endtask : blank_check

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'haa04d002));
    errors = 0;
    checks = 0;
    cycles = 0;
    reqDrv = '0;
    rst = 1'b1;
    {txData, txActive, rxActive, serialReceivePin, infrared_receive_pin} = 5'b00000;
    modeV = `IRC_RST_MODE;
    optV = `IRC_RST_OPT;
    blankV = `IRC_RST_BLANK;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    read_all();
    for (int i = 0; i < 24; i++) begin
      logic [7:0] idx;
      logic [7:0] v;
      idx = 8'hf0 + 8'($urandom_range(2, 0));
      v = 8'($urandom);
      if (idx == `IRC_IDX_BLANK) v = 8'($urandom_range(8'h64, 0));
      reg_wr(idx, v);
      read_all();
    end
    reg_rd(8'hf3, 8'h00);
    reg_rd(8'hef, 8'h00);
    reg_wr(8'hf3, 8'h5a);
    read_all();
    for (int pm = 0; pm < 8; pm++) begin
      route_check({pm[1:0], pm[2:0], 1'b0, 2'($urandom)}, 1'($urandom), 1'($urandom));
      route_check({pm[1:0], pm[2:0], 1'b0, 2'($urandom)}, 1'($urandom), 1'($urandom));
    end
    reg_wr(`IRC_IDX_OPT, 8'h04);
    blank_check(8'h00, 1'b1);
    blank_check(8'h01, 1'b0);
    blank_check(8'h03, 1'b1);
    blank_check(8'h64, 1'b0);
    reg_wr(`IRC_IDX_OPT, 8'h00);
    @(posedge core_clk);
    txActive <= 1'b1;
    rxActive <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk_bit(rxBlank, 1'b0);
    chk_bit(txBlank, 1'b0);
    chk_bit(cfg.halfDuplex, 1'b0);
    @(posedge core_clk);
    txActive <= 1'b0;
    rxActive <= 1'b0;
    reg_wr(`IRC_IDX_MODE, 8'hff);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    modeV = `IRC_RST_MODE;
    optV = `IRC_RST_OPT;
    blankV = `IRC_RST_BLANK;
    read_all();
    test_done();
  end
endmodule : tb
